// ### hdl/srcc_spi_slave.sv
// SPI register port slave: address byte then data bytes, address increments
`timescale 1ns/1ps
`default_nettype none
module srcc_spi_slave
   import srcc_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic spi_nss_n,
   input wire logic spi_sck,
   input wire logic spi_mosi,
   input wire logic [7:0] rdata,
   output logic [6:0] rd_addr,
   output logic wr_stb,
   output logic [6:0] wr_addr,
   output logic [7:0] wdata,
   output logic spi_miso,
   output logic spi_miso_oe
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // Pins are sampled, so sck must stay below about a sixth of mclk
   logic [1:0] nss_sync_reg, sck_sync_reg, mosi_sync_reg;
   logic sck_prev_reg;
   always_ff @(posedge mclk)
   begin
      nss_sync_reg <= {nss_sync_reg[0], spi_nss_n};
      sck_sync_reg <= {sck_sync_reg[0], spi_sck};
      mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
      sck_prev_reg <= sck_sync_reg[1];
   end
   wire logic sel = ~nss_sync_reg[1];
   wire logic rise = sel & sck_sync_reg[1] & ~sck_prev_reg;
   wire logic fall = sel & ~sck_sync_reg[1] & sck_prev_reg;
   wire logic [7:0] byte_in;

   // ---------------------------------------------------------------
   // Receive side
   // ---------------------------------------------------------------
   logic [6:0] shift_reg;
   logic [2:0] bit_reg;
   logic first_reg, write_reg, load_reg;
   assign byte_in = {shift_reg, mosi_sync_reg[1]};
   always_ff @(posedge mclk)
   begin
      wr_stb <= 1'b0;
      load_reg <= 1'b0;
      if (sys_rst || !sel)
      begin
         bit_reg <= 3'h0;
         first_reg <= 1'b1;
         write_reg <= 1'b0;
         shift_reg <= 7'h00;
         if (sys_rst)
         begin
            rd_addr <= 7'h00;
            wr_addr <= 7'h00;
            wdata <= 8'h00;
         end
      end
      else if (rise)
      begin
         shift_reg <= byte_in[6:0];
         bit_reg <= bit_reg + 3'h1;
         if (bit_reg == 3'h7)
         begin
            load_reg <= 1'b1;
            first_reg <= 1'b0;
            if (first_reg)
            begin
               write_reg <= byte_in[7];
               rd_addr <= byte_in[6:0];
            end
            else
            begin
               wr_stb <= write_reg;
               wr_addr <= rd_addr;
               wdata <= byte_in;
               rd_addr <= rd_addr + 7'h01;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Transmit side
   // ---------------------------------------------------------------
   // Load one cycle after a byte so rd_addr has already advanced
   // The fall that closes a byte comes after the load: it must not shift,
   // or the MSB would be gone before the master samples it
   logic [7:0] tx_reg;
   logic hold_fall_reg;
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         tx_reg <= 8'h00;
         spi_miso <= 1'b0;
         spi_miso_oe <= 1'b0;
         hold_fall_reg <= 1'b0;
      end
      else
      begin
         spi_miso_oe <= sel;
         if (load_reg)
         begin
            tx_reg <= rdata;
            spi_miso <= rdata[7];
            hold_fall_reg <= 1'b1;
         end
         else if (fall && hold_fall_reg)
            hold_fall_reg <= 1'b0;
         else if (fall)
         begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            spi_miso <= tx_reg[6];
         end
      end
   end
endmodule : srcc_spi_slave
`default_nettype wire

// ### hdl/srcc_synth_ctrl.sv
// Top: reference clock, carrier word and startup sequencer control
// Operation
// - Sequencer starts PLL once oscillator stable
// - Clock output idle until oscillator stable
// - Bit 4 at 0x59 selects external clock
// - Clock output divider select drives general I/O
// - Clock output stopped in Sleep and when divider select is 6 or 7
// - Clock output enabled after reset
// - Coarse cal at reset, fine per PLL start
// - Nineteen-bit modulator sets frequency step
// - Carrier is step times 24-bit word
// - Carrier word commits on low byte write
// - Sequencer starts RX or TX after lock
// - Lock indication high inside locking range
`timescale 1ns/1ps
`default_nettype none
module srcc_synth_ctrl
   import srcc_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic spi_nss_n,
   input wire logic spi_sck,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   input wire logic xo_stable_pin,
   input wire logic pll_lock_pin,
   input wire logic vco_cal_done_pin,
   output logic osc_enable,
   output logic ext_clk_select,
   output logic pll_enable,
   output logic vco_coarse_cal,
   output logic vco_fine_cal,
   output logic rx_enable,
   output logic tx_enable,
   output logic [SRCC_FRF_WIDTH-1:0] carrier_frequency_word,
   output logic general_io_five,
   output logic general_io_five_oe,
   output logic lock_indication
);
   // ---------------------------------------------------------------
   // Analog status synchronisers
   // ---------------------------------------------------------------
   logic [1:0] xo_sync_reg, lock_sync_reg, cal_sync_reg;
   always_ff @(posedge mclk)
   begin
      xo_sync_reg <= {xo_sync_reg[0], xo_stable_pin};
      lock_sync_reg <= {lock_sync_reg[0], pll_lock_pin};
      cal_sync_reg <= {cal_sync_reg[0], vco_cal_done_pin};
   end
   wire logic xo_s = xo_sync_reg[1];
   wire logic lock_s = lock_sync_reg[1];
   wire logic cal_s = cal_sync_reg[1];

   // ---------------------------------------------------------------
   // Register port
   // ---------------------------------------------------------------
   logic wr_stb;
   logic [6:0] wr_addr, rd_addr;
   logic [7:0] wdata, rdata;
   srcc_spi_slave u_spi (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .spi_nss_n(spi_nss_n),
      .spi_sck(spi_sck),
      .spi_mosi(spi_mosi),
      .rdata(rdata),
      .rd_addr(rd_addr),
      .wr_stb(wr_stb),
      .wr_addr(wr_addr),
      .wdata(wdata),
      .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe)
   );

   logic [7:0] opmode_reg, pinmap2_reg, xosc_cfg_reg;
   logic [7:0] frf_msb_reg, frf_mid_reg;
   logic [SRCC_FRF_WIDTH-1:0] frf_reg;
   srcc_state_t state_reg, state_next;
   wire srcc_mode_t mode = srcc_mode_t'(opmode_reg[SRCC_MODE_LSB +: 3]);
   wire logic seq_off = opmode_reg[SRCC_SEQ_OFF_BIT];
   wire logic [2:0] clk_sel = pinmap2_reg[2:0];
   wire logic low_write = wr_stb && wr_addr == SRCC_ADDR_FRF_LSB;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         opmode_reg <= SRCC_OPMODE_RST;
         pinmap2_reg <= SRCC_PINMAP2_RST;
         xosc_cfg_reg <= SRCC_XOSC_CFG_RST;
         frf_msb_reg <= SRCC_FRF_RST[23:16];
         frf_mid_reg <= SRCC_FRF_RST[15:8];
         frf_reg <= SRCC_FRF_RST;
      end
      else if (wr_stb)
      begin
         case (wr_addr)
            SRCC_ADDR_OPMODE: opmode_reg <= wdata;
            SRCC_ADDR_PINMAP2: pinmap2_reg <= wdata;
            SRCC_ADDR_XOSC_CFG: xosc_cfg_reg <= wdata;
            // Upper bytes wait in staging until the low byte lands
            SRCC_ADDR_FRF_MSB: frf_msb_reg <= wdata;
            SRCC_ADDR_FRF_MID: frf_mid_reg <= wdata;
            SRCC_ADDR_FRF_LSB:
               frf_reg <= {frf_msb_reg, frf_mid_reg, wdata};
            default: ;
         endcase
      end
   end

   // Staged upper bytes read back what software wrote
   always_comb
   begin
      case (rd_addr)
         SRCC_ADDR_OPMODE: rdata = opmode_reg;
         SRCC_ADDR_FRF_MSB: rdata = frf_msb_reg;
         SRCC_ADDR_FRF_MID: rdata = frf_mid_reg;
         SRCC_ADDR_FRF_LSB: rdata = frf_reg[7:0];
         SRCC_ADDR_PINMAP2: rdata = pinmap2_reg;
         SRCC_ADDR_STATUS:
            rdata = {5'h00, state_reg == SRCC_ST_READY, xo_s, lock_s};
         SRCC_ADDR_XOSC_CFG: rdata = xosc_cfg_reg;
         default: rdata = 8'h00;
      endcase
   end
   assign ext_clk_select = xosc_cfg_reg[SRCC_EXTCLK_BIT];
   assign carrier_frequency_word = frf_reg;

   // ---------------------------------------------------------------
   // Startup sequencer
   // ---------------------------------------------------------------
   wire logic want_pll = mode == SRCC_MODE_FS || mode == SRCC_MODE_TX ||
                         mode == SRCC_MODE_RX;
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         SRCC_ST_POR_OSC:
            if (xo_s)
               state_next = SRCC_ST_COARSE;
         SRCC_ST_COARSE:
            if (cal_s)
               state_next = SRCC_ST_IDLE;
         SRCC_ST_IDLE:
            if (seq_off)
               state_next = SRCC_ST_MANUAL;
            else if (mode == SRCC_MODE_SLEEP)
               state_next = SRCC_ST_SLEEP;
            else if (want_pll && xo_s)
               state_next = SRCC_ST_FINE;
         SRCC_ST_FINE:
            if (!want_pll || seq_off)
               state_next = SRCC_ST_IDLE;
            else if (cal_s)
               state_next = SRCC_ST_LOCK;
         SRCC_ST_LOCK:
            if (!want_pll || seq_off)
               state_next = SRCC_ST_IDLE;
            else if (lock_s)
               state_next = SRCC_ST_READY;
         SRCC_ST_READY:
            if (!want_pll || seq_off)
               state_next = SRCC_ST_IDLE;
         SRCC_ST_SLEEP:
            if (mode != SRCC_MODE_SLEEP && xo_s)
               state_next = SRCC_ST_IDLE;
         SRCC_ST_MANUAL:
            if (!seq_off)
               state_next = SRCC_ST_IDLE;
         default: state_next = SRCC_ST_POR_OSC;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         state_reg <= SRCC_ST_POR_OSC;
      else
         state_reg <= state_next;
   end

   // Outputs follow the next state so they change with the state
   logic pll_next, rx_next, tx_next, osc_next, manual_next;
   always_comb
   begin
      manual_next = state_next == SRCC_ST_MANUAL;
      osc_next = !(state_next == SRCC_ST_SLEEP && mode == SRCC_MODE_SLEEP)
                 && !(manual_next && mode == SRCC_MODE_SLEEP);
      pll_next = state_next == SRCC_ST_FINE || state_next == SRCC_ST_LOCK ||
                 state_next == SRCC_ST_READY || (manual_next && want_pll);
      tx_next = mode == SRCC_MODE_TX &&
                (state_next == SRCC_ST_READY || manual_next);
      rx_next = mode == SRCC_MODE_RX &&
                (state_next == SRCC_ST_READY || manual_next);
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         osc_enable <= 1'b1;
         pll_enable <= 1'b0;
         tx_enable <= 1'b0;
         rx_enable <= 1'b0;
         vco_coarse_cal <= 1'b0;
         vco_fine_cal <= 1'b0;
         lock_indication <= 1'b0;
      end
      else
      begin
         osc_enable <= osc_next;
         pll_enable <= pll_next;
         tx_enable <= tx_next;
         rx_enable <= rx_next;
         vco_coarse_cal <= state_reg == SRCC_ST_POR_OSC &&
                           state_next == SRCC_ST_COARSE;
         vco_fine_cal <= pll_next && !pll_enable;
         lock_indication <= lock_s && pll_enable;
      end
   end

   // ---------------------------------------------------------------
   // Reference clock output on general I/O five
   // ---------------------------------------------------------------
   // Fastest available output is mclk/2 since the pin comes off a flop
   logic [5:0] div_reg;
   wire logic clk_on = xo_s && osc_enable && clk_sel < SRCC_REFERENCE_CLOCK_OUTPUT_OFF &&
                       state_reg != SRCC_ST_SLEEP;
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         div_reg <= 6'h00;
         general_io_five <= 1'b0;
         general_io_five_oe <= 1'b0;
      end
      else
      begin
         div_reg <= div_reg + 6'h01;
         general_io_five_oe <= clk_on;
         general_io_five <= clk_on && div_reg[clk_sel];
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_low_write;
      low_write;
   endsequence
   sequence s_upper_write;
      wr_stb && (wr_addr == SRCC_ADDR_FRF_MSB ||
                 wr_addr == SRCC_ADDR_FRF_MID);
   endsequence
   sequence s_lock_to_run;
      state_reg == SRCC_ST_LOCK && want_pll && !seq_off && lock_s;
   endsequence

   a_pll_auto_start: assert property (@(posedge mclk) disable iff (sys_rst)
      state_reg == SRCC_ST_IDLE && !seq_off && want_pll && xo_s
      |=> pll_enable && vco_fine_cal)
      else $error("PLL not started after oscillator stable");
   a_reference_clock_output_gated: assert property (@(posedge mclk) disable iff (sys_rst)
      !xo_s |=> !general_io_five_oe && !general_io_five)
      else $error("Clock output active before oscillator stable");
   a_ext_clk_sel: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_stb && wr_addr == SRCC_ADDR_XOSC_CFG
      |=> ext_clk_select == $past(wdata[SRCC_EXTCLK_BIT]))
      else $error("External clock select not taken from write");
   a_reference_clock_output_sleep: assert property (@(posedge mclk) disable iff (sys_rst)
      state_reg == SRCC_ST_SLEEP |=> !general_io_five_oe)
      else $error("Clock output running in sleep");
   a_reference_clock_output_por: assert property (@(posedge mclk)
      sys_rst |=> pinmap2_reg[2:0] < SRCC_REFERENCE_CLOCK_OUTPUT_OFF)
      else $error("Clock output not enabled after reset");
   a_fine_on_start: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(pll_enable) |-> vco_fine_cal ##1 !vco_fine_cal)
      else $error("Fine calibration not pulsed at PLL start");
   a_frf_commit: assert property (@(posedge mclk) disable iff (sys_rst)
      s_low_write |=> carrier_frequency_word ==
      {$past(frf_msb_reg), $past(frf_mid_reg), $past(wdata)})
      else $error("Carrier word not committed on low byte");
   a_frf_hold: assert property (@(posedge mclk) disable iff (sys_rst)
      s_upper_write |=> $stable(carrier_frequency_word))
      else $error("Carrier word changed on upper byte write");
   a_run_after_lock: assert property (@(posedge mclk) disable iff (sys_rst)
      s_lock_to_run ##0 mode == SRCC_MODE_TX |=> tx_enable && !rx_enable)
      else $error("Transmitter not started after lock");
   a_lock_ind: assert property (@(posedge mclk) disable iff (sys_rst)
      lock_s && pll_enable |=> lock_indication)
      else $error("Lock indication missing while locked");
endmodule : srcc_synth_ctrl
`default_nettype wire

// ### inc/srcc_pkg.sv
// Package: register map, field layout and states of the synth clock control
package srcc_pkg;
   localparam logic [6:0] SRCC_ADDR_OPMODE = 7'h01;
   localparam logic [6:0] SRCC_ADDR_FRF_MSB = 7'h07;
   localparam logic [6:0] SRCC_ADDR_FRF_MID = 7'h08;
   localparam logic [6:0] SRCC_ADDR_FRF_LSB = 7'h09;
   localparam logic [6:0] SRCC_ADDR_PINMAP2 = 7'h26;
   localparam logic [6:0] SRCC_ADDR_STATUS = 7'h27;
   localparam logic [6:0] SRCC_ADDR_XOSC_CFG = 7'h59;
   localparam int SRCC_EXTCLK_BIT = 4;
   localparam int SRCC_SEQ_OFF_BIT = 7;
   localparam int SRCC_MODE_LSB = 2;
   localparam int SRCC_FRF_WIDTH = 24;
   // Sigma-delta resolution: step = oscillator_frequency / 2**19
   localparam int SRCC_SDM_BITS = 19;
   localparam logic [7:0] SRCC_OPMODE_RST = 8'h04;
   localparam logic [7:0] SRCC_PINMAP2_RST = 8'h00;
   localparam logic [7:0] SRCC_XOSC_CFG_RST = 8'h00;
   localparam logic [23:0] SRCC_FRF_RST = 24'h000000;
   localparam logic [2:0] SRCC_REFERENCE_CLOCK_OUTPUT_OFF = 3'h6;
   typedef enum logic [2:0] {
      SRCC_MODE_SLEEP = 3'b000,
      SRCC_MODE_STBY = 3'b001,
      SRCC_MODE_FS = 3'b010,
      SRCC_MODE_TX = 3'b011,
      SRCC_MODE_RX = 3'b100
   } srcc_mode_t;
   typedef enum logic [2:0] {
      SRCC_ST_POR_OSC = 3'b000,
      SRCC_ST_COARSE = 3'b001,
      SRCC_ST_IDLE = 3'b010,
      SRCC_ST_FINE = 3'b011,
      SRCC_ST_LOCK = 3'b100,
      SRCC_ST_READY = 3'b101,
      SRCC_ST_SLEEP = 3'b110,
      SRCC_ST_MANUAL = 3'b111
   } srcc_state_t;
endpackage : srcc_pkg

// ### tb/srcc_host_model.sv
// Host microcontroller model: SPI mode 0 master on the register port
`timescale 1ns/1ps
`default_nettype none
module srcc_host_model
(
   input wire logic mclk,
   output logic spi_nss_n,
   output logic spi_sck,
   output logic spi_mosi,
   input wire logic spi_miso,
   input wire logic spi_miso_oe,
   input wire logic general_io_five,
   input wire logic lock_indication
);
   // ------------------------------------------------------------
   // Bus cycles
   // ------------------------------------------------------------
   initial
   begin
      spi_nss_n = 1'b1;
      spi_sck = 1'b0;
      spi_mosi = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick

   // Five clocks per half period keeps sck inside the sync limit
   task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         spi_mosi = tx[i];
         tick(5);
         spi_sck = 1'b1;
         rx[i] = spi_miso_oe ? spi_miso : 1'bx;
         tick(5);
         spi_sck = 1'b0;
      end
   endtask : spi_byte

   task automatic xfer(input logic wr, input logic [6:0] a, input int n,
      input logic [23:0] wd, output logic [23:0] rd);
      logic [7:0] rb;
      rd = 24'h000000;
      spi_nss_n = 1'b0;
      tick(4);
      spi_byte({wr, a}, rb);
      for (int k = 0; k < n; k++)
      begin
         spi_byte(wd[8*(n-1-k) +: 8], rb);
         rd[8*(n-1-k) +: 8] = rb;
      end
      tick(5);
      spi_nss_n = 1'b1;
      // Data line means nothing between frames, so keep it moving
      spi_mosi = ~spi_mosi;
      tick(6);
   endtask : xfer

   // ------------------------------------------------------------
   // Startup waits on the indications, bounded
   // ------------------------------------------------------------
   task automatic wait_pin(input logic sel, input int limit,
      output logic seen);
      seen = 1'b0;
      for (int i = 0; i < limit && !seen; i++)
      begin
         tick(1);
         seen = sel ? (lock_indication === 1'b1) : (general_io_five === 1'b1);
      end
   endtask : wait_pin
endmodule : srcc_host_model
`default_nettype wire

// ### tb/tb_top.sv
// Testbench for the synth reference clock control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import srcc_pkg::*;
;
   logic mclk = 1'b0;
   logic sys_rst;
   logic spi_nss_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe;
   logic xo_stable_pin, pll_lock_pin, vco_cal_done_pin;
   logic osc_enable, ext_clk_select, pll_enable, vco_coarse_cal;
   logic vco_fine_cal, rx_enable, tx_enable, general_io_five;
   logic general_io_five_oe, lock_indication, seen, prev_io;
   logic [SRCC_FRF_WIDTH-1:0] carrier_frequency_word;
   logic [31:0] seed = 32'h84D507C3;
   logic [31:0] rnd;
   logic xo_allow = 1'b0;
   logic lock_allow = 1'b0;
   int num_errors = 0, checks_done = 0, cyc = 0, last_rise = 0;
   int rise_gap = 0, toggles = 0, xo_cnt = 0, cal_cnt = 0, lock_cnt = 0;
   int coarse_seen = 0, fine_seen = 0, mdl_word = 0;
   int mdl [128];

   always #20 mclk = ~mclk;

   srcc_synth_ctrl dut (.mclk(mclk), .sys_rst(sys_rst),
      .spi_nss_n(spi_nss_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
      .xo_stable_pin(xo_stable_pin), .pll_lock_pin(pll_lock_pin),
      .vco_cal_done_pin(vco_cal_done_pin), .osc_enable(osc_enable),
      .ext_clk_select(ext_clk_select), .pll_enable(pll_enable),
      .vco_coarse_cal(vco_coarse_cal), .vco_fine_cal(vco_fine_cal),
      .rx_enable(rx_enable), .tx_enable(tx_enable),
      .carrier_frequency_word(carrier_frequency_word),
      .general_io_five(general_io_five),
      .general_io_five_oe(general_io_five_oe),
      .lock_indication(lock_indication));

   srcc_host_model host (.mclk(mclk), .spi_nss_n(spi_nss_n),
      .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .general_io_five(general_io_five),
      .lock_indication(lock_indication));

   // ------------------------------------------------------------
   // Analog side: oscillator, VCO calibration, PLL lock
   // ------------------------------------------------------------
   always @(posedge mclk)
   begin
      #1;
      cyc++;
      xo_cnt = (osc_enable === 1'b1 && xo_allow) ? xo_cnt + 1 : 0;
      xo_stable_pin = (xo_cnt > 30);
      if (vco_coarse_cal === 1'b1 || vco_fine_cal === 1'b1)
         cal_cnt = 0;
      else if (cal_cnt < 100)
         cal_cnt++;
      vco_cal_done_pin = (cal_cnt > 8);
      lock_cnt = (pll_enable === 1'b1 && lock_allow) ? lock_cnt + 1 : 0;
      pll_lock_pin = (lock_cnt > 20);
      coarse_seen += (vco_coarse_cal === 1'b1);
      fine_seen += (vco_fine_cal === 1'b1);
      toggles += (general_io_five !== prev_io);
      if (general_io_five === 1'b1 && prev_io === 1'b0)
      begin
         rise_gap = cyc - last_rise;
         last_rise = cyc;
      end
      prev_io = general_io_five;
   end

   // ------------------------------------------------------------
   // Checking and register model
   // ------------------------------------------------------------
   function automatic logic [31:0] next_rand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : next_rand

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t ns: %s got %0h want %0h", $time, what, got,
            exp);
      end
   endtask : check

   task automatic wr(input logic [6:0] a, input int n, input logic [23:0] d);
      logic [23:0] r;
      host.xfer(1'b1, a, n, d, r);
      for (int k = 0; k < n; k++)
      begin
         mdl[a+k] = d[8*(n-1-k) +: 8];
         if (a + k == SRCC_ADDR_FRF_LSB)
            mdl_word = (mdl[7] << 16) | (mdl[8] << 8) | mdl[9];
      end
      check(carrier_frequency_word, mdl_word, "carrier word");
   endtask : wr

   task automatic rd_chk(input logic [6:0] a, input logic [7:0] e,
      input logic [7:0] m);
      logic [23:0] r;
      host.xfer(1'b0, a, 1, 24'h000000, r);
      check(r[7:0] & m, e, "read data");
   endtask : rd_chk

   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   // Generous bound: the sequence needs about 13000 cycles
   initial
   begin
      repeat (60000) @(posedge mclk);
      num_errors++;
      finish_test;
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial
   begin
      sys_rst = 1'b1;
      repeat (5) @(posedge mclk);
      #1;
      check({osc_enable, pll_enable, rx_enable, tx_enable, ext_clk_select,
         general_io_five_oe}, 6'h20, "reset levels");
      check(carrier_frequency_word, SRCC_FRF_RST, "reset word");
      sys_rst = 1'b0;
      toggles = 0;
      host.tick(40);
      check(general_io_five_oe, 1'b0, "clock out early");
      check(toggles, 0, "clock out toggles early");
      check(coarse_seen, 0, "coarse cal early");
      xo_allow = 1'b1;
      host.wait_pin(1'b0, 300, seen);
      check(seen, 1'b1, "clock out after stable");
      check(general_io_five_oe, 1'b1, "clock out drive");
      host.tick(20);
      check(coarse_seen, 1, "coarse cal once");
      check(pll_enable, 1'b0, "pll off in standby");
      $display("Test startup done");
      for (int n = 0; n < 8; n++)
      begin
         wr(SRCC_ADDR_PINMAP2, 1, 24'(n));
         toggles = 0;
         host.tick((8 << n) + 20);
         if (n < 6)
            check(rise_gap, 2 << n, "divider period");
         else
            check(toggles, 0, "divider off");
         rd_chk(SRCC_ADDR_PINMAP2, 8'(n), 8'hFF);
      end
      wr(SRCC_ADDR_PINMAP2, 1, 24'h000000);
      $display("Test divider done");
      for (int k = 0; k < 3; k++)
      begin
         rnd = next_rand();
         wr(SRCC_ADDR_FRF_MSB, 1, {16'h0000, rnd[23:16]});
         rd_chk(SRCC_ADDR_FRF_MSB, rnd[23:16], 8'hFF);
         wr(SRCC_ADDR_FRF_MID, 1, {16'h0000, rnd[15:8]});
         rd_chk(SRCC_ADDR_FRF_MID, rnd[15:8], 8'hFF);
         // Mid byte stays staged from before when only MSB and LSB change
         wr(SRCC_ADDR_FRF_MSB, 1, {16'h0000, rnd[31:24]});
         wr(SRCC_ADDR_FRF_LSB, 1, {16'h0000, rnd[7:0]});
         rnd = next_rand();
         wr(SRCC_ADDR_FRF_MSB, 3, rnd[23:0]);
      end
      $display("Test carrier done");
      wr(SRCC_ADDR_XOSC_CFG, 1, 24'h000010);
      check(ext_clk_select, 1'b1, "external clock on");
      rd_chk(SRCC_ADDR_XOSC_CFG, 8'h10, 8'hFF);
      wr(SRCC_ADDR_XOSC_CFG, 1, 24'h000000);
      check(ext_clk_select, 1'b0, "external clock off");
      wr(7'h30, 1, 24'h0000A5);
      rd_chk(7'h30, 8'h00, 8'hFF);
      $display("Test registers done");
      for (int k = 2; k < 5; k++)
      begin
         lock_allow = 1'b0;
         fine_seen = 0;
         wr(SRCC_ADDR_OPMODE, 1, 24'(k << SRCC_MODE_LSB));
         host.tick(30);
         check(pll_enable, 1'b1, "pll on");
         check(fine_seen, 1, "fine cal");
         check({rx_enable, tx_enable}, 2'b00, "rx tx before lock");
         check(lock_indication, 1'b0, "lock early");
         lock_allow = 1'b1;
         host.wait_pin(1'b1, 200, seen);
         check(seen, 1'b1, "lock indication");
         host.tick(4);
         check(rx_enable, k == 4, "rx after lock");
         check(tx_enable, k == 3, "tx after lock");
         rd_chk(SRCC_ADDR_STATUS, 8'h03, 8'h03);
         // Lock may drop in wide deviation; host carries on
         lock_allow = 1'b0;
         host.tick(8);
         check(lock_indication, 1'b0, "lock drop");
         wr(SRCC_ADDR_OPMODE, 1, 24'(int'(SRCC_MODE_STBY) << SRCC_MODE_LSB));
         check({pll_enable, rx_enable, tx_enable}, 3'b000, "standby");
      end
      $display("Test sequencer done");
      wr(SRCC_ADDR_OPMODE, 1, 24'(int'(SRCC_MODE_SLEEP) << SRCC_MODE_LSB));
      check(osc_enable, 1'b0, "sleep osc");
      toggles = 0;
      host.tick(40);
      check(toggles, 0, "sleep clock out");
      wr(SRCC_ADDR_OPMODE, 1, 24'(int'(SRCC_MODE_FS) << SRCC_MODE_LSB));
      check(pll_enable, 1'b0, "pll waits oscillator");
      for (int i = 0; i < 300 && pll_enable !== 1'b1; i++)
         host.tick(1);
      check(pll_enable, 1'b1, "pll after wake");
      host.wait_pin(1'b0, 100, seen);
      check(seen, 1'b1, "clock out after wake");
      // Clock output no longer needed
      wr(SRCC_ADDR_PINMAP2, 1, 24'(SRCC_REFERENCE_CLOCK_OUTPUT_OFF));
      check(general_io_five_oe, 1'b0, "clock out off");
      $display("Test sleep done");
      // Mid-run reset must bring the clock output back with no write
      sys_rst = 1'b1;
      host.tick(3);
      sys_rst = 1'b0;
      check(carrier_frequency_word, SRCC_FRF_RST, "word reset");
      check(pll_enable, 1'b0, "pll off after reset");
      host.wait_pin(1'b0, 300, seen);
      check(seen, 1'b1, "clock out after reset");
      $display("Test reset done");
      finish_test;
   end
endmodule : tb_top
`default_nettype wire
